// ### mbt_regs.svh
// constants of the request handler: codes, lengths, limits
`ifndef MBT_REGS_SVH
`define MBT_REGS_SVH
`define MBT_FC_LOOP 8'h08
`define MBT_FC_WMULT 8'h10
`define MBT_FC_EXC 8'h80
`define MBT_PROTO_ID 16'h0000
`define MBT_LEN_NORMAL 16'h0006
`define MBT_LEN_EXC 16'h0003
`define MBT_WMULT_OVH 16'h0007
`define MBT_HDR_BYTES 16'h0006
`define MBT_MIN_FRAME 8'h08
`define MBT_MAX_LEN 16'h0100
`define MBT_MAX_WORDS 16'h0020
`define MBT_WORD_LIMIT 17'h00190
`define MBT_UNIT_BCAST 8'h00
`define MBT_UNIT_MAX 8'h63
`define MBT_ERR_FUNC 8'h01
`define MBT_ERR_ADDR 8'h02
`define MBT_ERR_COUNT 8'h03
`define MBT_IDX_DATA 8'h0D
`define MBT_TX_NORMAL 4'hC
`define MBT_TX_EXC 4'h9
`endif

// ### mbt_pkg.sv
// types of the request handler
package mbt_pkg;
  typedef enum logic [1:0] {
    MBT_ST_RX = 2'h0,
    MBT_ST_DEC = 2'h1,
    MBT_ST_COMMIT = 2'h3,
    MBT_ST_SEND = 2'h2
  } mbt_state_t;
  typedef logic [15:0] mbt_word_t;
endpackage : mbt_pkg

// ### mbt_rsp_if.sv
// response descriptor passed from the handler to the byte sender
`timescale 1ns/10ps
interface mbt_rsp_if;
  logic start;
  logic exc;
  logic [15:0] tid;
  logic [7:0] unit;
  logic [7:0] fc;
  logic [15:0] w1;
  logic [15:0] w2;
  logic [7:0] ecode;
  logic done;
  modport src (output start, exc, tid, unit, fc, w1, w2, ecode, input done);
  modport snk (input start, exc, tid, unit, fc, w1, w2, ecode, output done);
endinterface : mbt_rsp_if

// ### mbt_tx.sv
// response byte sender: serialises header and answer onto the tx stream
`timescale 1ns/10ps
`include "mbt_regs.svh"
module mbt_tx import mbt_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic conn_up,
  mbt_rsp_if.snk rsp,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last
);
  logic act_r;
  logic [3:0] bi_r;
  logic done_r;
  logic [3:0] nbytes;
  logic [7:0] byte_sel;
  logic can_load;
  logic end_hit;

  function automatic logic [7:0] pick(input logic [3:0] i, input logic e);
    logic [15:0] len;
    len = e ? `MBT_LEN_EXC : `MBT_LEN_NORMAL;
    case (i)
      4'h0: pick = rsp.tid[15:8];
      4'h1: pick = rsp.tid[7:0];
      4'h2: pick = 8'(`MBT_PROTO_ID >> 8);
      4'h3: pick = 8'(`MBT_PROTO_ID);
      4'h4: pick = len[15:8];
      4'h5: pick = len[7:0];
      4'h6: pick = rsp.unit;
      4'h7: pick = e ? (rsp.fc | `MBT_FC_EXC) : rsp.fc;
      4'h8: pick = e ? rsp.ecode : rsp.w1[15:8];
      4'h9: pick = rsp.w1[7:0];
      4'hA: pick = rsp.w2[15:8];
      4'hB: pick = rsp.w2[7:0];
      default: pick = 8'h00;
    endcase
  endfunction : pick

  // tid echoed, pid fixed zero, length six or three
  assign nbytes = rsp.exc ? `MBT_TX_EXC : `MBT_TX_NORMAL; // R6 R10
  // pick reads the descriptor directly; a plain assign would not wake on
  // those reads and could show a stale header byte
  always_comb byte_sel = pick(bi_r, rsp.exc); // R1 R5 R10
  assign can_load = act_r && (bi_r != nbytes) && (!tx_valid || tx_ready);
  assign end_hit = tx_valid && tx_ready && tx_last;
  assign rsp.done = done_r;

  always_ff @(posedge mclk) begin
    if (rst || !conn_up) begin
      act_r <= 1'b0;
      bi_r <= 4'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      done_r <= rst ? 1'b0 : act_r; // a lost connection ends the answer
    end else begin
      done_r <= 1'b0;
      if (rsp.start) begin
        act_r <= 1'b1;
        bi_r <= 4'h0;
      end else if (end_hit) begin
        act_r <= 1'b0;
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
        done_r <= 1'b1;
      end else if (can_load) begin
        tx_valid <= 1'b1;
        tx_data <= byte_sel;
        tx_last <= (bi_r == nbytes - 4'h1);
        bi_r <= bi_r + 4'h1;
      end
    end
  end
endmodule : mbt_tx

// ### mbt_handler.sv
// request handler: parses requests, writes holding words, starts answers
// Behaviour
// R1: loopback echoes transaction id, length six, unit, zero word, payload.
// R2: a multiple write covers at most thirty-two consecutive words.
// R3: multiple write to unit zero is performed and never answered.
// R4: host frames writes with code 10, length 2n+7, count n, bytes 2n.
// R5: good write answers length six, code 10, start and count echoed.
// R6: protocol id is zero; transaction id is copied back unchanged.
// R7: addressed unit is 1 to 99 and is echoed in the answer.
// R8: start field is the one-based word number minus one.
// R9: a float spanning two words puts its low half first.
// R10: bad PDU is not executed; exception with length three, code plus 80.
// R11: error 01 unknown code, 02 word number range, 03 word count range.
// R12: requests are dropped unanswered while no connection is up.
// R13: requests with an inconsistent MBAP header are dropped silently.
// R14: relayed requests to a failing serial station are dropped silently.
// R15: host keeps a timeout since several failures give no answer.
// R16: count above 32 or byte count not twice count gives error 03.
`timescale 1ns/10ps
`include "mbt_regs.svh"
module mbt_handler import mbt_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic conn_up,
  input wire logic [7:0] local_unit,
  input wire logic gw_ok,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic wr_en,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data
);
  mbt_rsp_if rsp ();

  mbt_state_t state_r;
  mbt_state_t state_nxt;
  logic [7:0] cnt_r;
  logic ovf_r;
  logic [15:0] tid_r;
  logic [15:0] pid_r;
  logic [15:0] len_r;
  logic [7:0] unit_r;
  logic [7:0] fc_r;
  logic [15:0] w1_r;
  logic [15:0] w2_r;
  logic [7:0] bc_r;
  logic [7:0] hi_r;
  mbt_word_t buf_r [32];
  logic [5:0] k_r;
  logic start_r;
  logic exc_r;
  logic [7:0] ecode_r;
  logic bcast_r;

  logic take;
  logic [7:0] didx;
  logic [6:0] wslot;
  logic buf_we;
  logic is_loop;
  logic is_wr;
  logic bcast;
  logic relayed;
  logic tot_ok;
  logic mbap_ok;
  logic len_ok;
  logic cnt_bad;
  logic addr_bad;
  logic pdu_ok;
  logic drop;
  logic [7:0] ecode_sel;
  logic commit_last;

  assign take = rx_ready && rx_valid && conn_up;
  assign didx = cnt_r - `MBT_IDX_DATA;
  assign wslot = didx[7:1];
  assign buf_we = take && (cnt_r >= `MBT_IDX_DATA) && didx[0]
    && (wslot < 7'h20);

  assign is_loop = (fc_r == `MBT_FC_LOOP);
  assign is_wr = (fc_r == `MBT_FC_WMULT);
  assign bcast = (unit_r == `MBT_UNIT_BCAST);
  assign relayed = !bcast && (unit_r != local_unit);
  // header must agree with the bytes actually received
  assign tot_ok = ({8'h00, cnt_r} == len_r + `MBT_HDR_BYTES);
  assign mbap_ok = (pid_r == `MBT_PROTO_ID) && !ovf_r // R6 R13
    && (cnt_r >= `MBT_MIN_FRAME) && (len_r < `MBT_MAX_LEN) && tot_ok;
  assign len_ok = is_loop ? (len_r == `MBT_LEN_NORMAL) // R13
    : is_wr ? (len_r == {8'h00, bc_r} + `MBT_WMULT_OVH) : 1'b1; // R4
  assign cnt_bad = (w2_r == 16'h0000) || (w2_r > `MBT_MAX_WORDS) // R2 R16
    || ({8'h00, bc_r} != {w2_r[14:0], 1'b0}); // R16
  assign addr_bad = ({1'b0, w1_r} + {1'b0, w2_r}) > `MBT_WORD_LIMIT; // R8
  // a nonzero loopback sub-word is treated as an unsupported function
  assign ecode_sel = (!is_loop && !is_wr) ? `MBT_ERR_FUNC // R11
    : is_loop ? ((w1_r != 16'h0000) ? `MBT_ERR_FUNC : 8'h00) // R11
    : cnt_bad ? `MBT_ERR_COUNT : addr_bad ? `MBT_ERR_ADDR : 8'h00; // R11
  assign pdu_ok = (ecode_sel == 8'h00);
  assign drop = !conn_up || !mbap_ok || !len_ok // R12 R13
    || (unit_r > `MBT_UNIT_MAX) // R7
    || (relayed && !gw_ok) // R14
    || (bcast && !(is_wr && pdu_ok)); // R3
  assign commit_last = ({10'h000, k_r} == w2_r - 16'h0001);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MBT_ST_RX: if (take && rx_last) state_nxt = MBT_ST_DEC;
      MBT_ST_DEC: begin
        if (drop) state_nxt = MBT_ST_RX;
        else if (is_wr && pdu_ok) state_nxt = MBT_ST_COMMIT; // R10
        else state_nxt = MBT_ST_SEND;
      end
      MBT_ST_COMMIT: begin
        if (commit_last) state_nxt = bcast_r ? MBT_ST_RX : MBT_ST_SEND; // R3
      end
      MBT_ST_SEND: if (rsp.done) state_nxt = MBT_ST_RX;
      default: state_nxt = MBT_ST_RX;
    endcase
    if (!conn_up) state_nxt = MBT_ST_RX; // R12
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= MBT_ST_RX;
      rx_ready <= 1'b0;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rx_ready <= (state_nxt == MBT_ST_RX) && conn_up;
      start_r <= (state_nxt == MBT_ST_SEND) && (state_r != MBT_ST_SEND);
    end
  end

  // byte counter: a partial frame is forgotten when the link drops
  always_ff @(posedge mclk) begin
    if (rst || !conn_up || state_r == MBT_ST_DEC) begin // R12
      cnt_r <= 8'h00;
      ovf_r <= 1'b0;
    end else if (take) begin
      cnt_r <= (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
      ovf_r <= ovf_r || (cnt_r == 8'hFF);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tid_r <= 16'h0000;
      pid_r <= 16'h0000;
      len_r <= 16'h0000;
      unit_r <= 8'h00;
      fc_r <= 8'h00;
      w1_r <= 16'h0000;
      w2_r <= 16'h0000;
      bc_r <= 8'h00;
      hi_r <= 8'h00;
    end else if (take) begin
      case (cnt_r)
        8'h00: tid_r[15:8] <= rx_data;
        8'h01: tid_r[7:0] <= rx_data;
        8'h02: pid_r[15:8] <= rx_data;
        8'h03: pid_r[7:0] <= rx_data;
        8'h04: len_r[15:8] <= rx_data;
        8'h05: len_r[7:0] <= rx_data;
        8'h06: unit_r <= rx_data;
        8'h07: fc_r <= rx_data;
        8'h08: w1_r[15:8] <= rx_data;
        8'h09: w1_r[7:0] <= rx_data;
        8'h0A: w2_r[15:8] <= rx_data;
        8'h0B: w2_r[7:0] <= rx_data;
        8'h0C: bc_r <= rx_data;
        default: hi_r <= rx_data;
      endcase
    end
  end

  // words are held until the whole frame is checked, so a bad frame
  // never reaches the holding words; costs 32 words of flip-flops
  for (genvar g = 0; g < 32; g++) begin : g_buf
    always_ff @(posedge mclk) begin
      if (rst) begin
        buf_r[g] <= 16'h0000;
      end else if (buf_we && wslot == 7'(g)) begin
        buf_r[g] <= {hi_r, rx_data}; // R9
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      exc_r <= 1'b0;
      ecode_r <= 8'h00;
      bcast_r <= 1'b0;
    end else if (state_r == MBT_ST_DEC) begin
      exc_r <= !pdu_ok; // R10
      ecode_r <= ecode_sel; // R11
      bcast_r <= bcast;
    end
  end

  // commit: one word per cycle at start field plus offset
  always_ff @(posedge mclk) begin
    if (rst) begin
      k_r <= 6'h00;
      wr_en <= 1'b0;
      wr_addr <= 16'h0000;
      wr_data <= 16'h0000;
    end else begin
      wr_en <= (state_r == MBT_ST_COMMIT) && conn_up; // R3
      if (state_r == MBT_ST_COMMIT) begin
        wr_addr <= w1_r + {10'h000, k_r}; // R8
        wr_data <= buf_r[k_r[4:0]];
        k_r <= k_r + 6'h01;
      end else begin
        k_r <= 6'h00;
      end
    end
  end

  assign rsp.start = start_r;
  assign rsp.exc = exc_r;
  assign rsp.tid = tid_r; // R6
  assign rsp.unit = unit_r; // R7
  assign rsp.fc = fc_r;
  assign rsp.w1 = w1_r; // R1 R5
  assign rsp.w2 = w2_r; // R1 R5
  assign rsp.ecode = ecode_r;

  mbt_tx u_tx (
    .mclk(mclk),
    .rst(rst),
    .conn_up(conn_up),
    .rsp(rsp),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last)
  );
endmodule : mbt_handler

// ### mbt_handler_asserts.sv
// port checks for the request handler
`timescale 1ns/10ps
module mbt_handler_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic conn_up,
  input wire logic rx_ready,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic wr_en,
  input wire logic [15:0] wr_addr
);
  logic [3:0] idx_r;
  logic [5:0] run_r;
  wire acc = tx_valid && tx_ready;
  // byte position within the answer, cleared on abort too
  always_ff @(posedge mclk) begin
    if (rst || !conn_up || (acc && tx_last)) idx_r <= 4'h0;
    else if (acc) idx_r <= idx_r + 4'h1;
  end
  always_ff @(posedge mclk) begin
    run_r <= (rst || !wr_en) ? 6'h00 : run_r + 6'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_pid_zero:
    assert property (tx_valid && idx_r inside {[4'h2:4'h4]} |->
      tx_data == 8'h00) else $error("header zero byte wrong");
  chk_len_low:
    assert property (tx_valid && idx_r == 4'h5 |->
      tx_data inside {8'h03, 8'h06}) else $error("length byte wrong");
  chk_end_pos:
    assert property (tx_valid && tx_last |-> idx_r == 4'h8 || idx_r == 4'hB)
      else $error("answer length wrong");
  chk_tx_hold:
    assert property (tx_valid && !tx_ready && conn_up |=>
      tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("answer byte not held");
  chk_last_drop:
    assert property (acc && tx_last |=> !tx_valid)
      else $error("bytes after last");
  chk_down_quiet:
    assert property ((!conn_up) [*2] |-> !tx_valid && !rx_ready)
      else $error("active without connection");
  chk_wr_step:
    assert property (wr_en && $past(wr_en) |->
      wr_addr == $past(wr_addr) + 16'h0001) else $error("write not ascending");
  chk_wr_max:
    assert property (wr_en |-> run_r < 6'h20) else $error("burst over 32");
  cov_loop: cover property (acc && tx_last && idx_r == 4'hB);
  cov_exc: cover property (acc && tx_last && idx_r == 4'h8);
  cov_burst: cover property (wr_en [*4]);
endmodule : mbt_handler_chk
bind mbt_handler mbt_handler_chk u_chk (.mclk(mclk), .rst(rst),
  .conn_up(conn_up), .rx_ready(rx_ready), .tx_ready(tx_ready),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .wr_en(wr_en), .wr_addr(wr_addr));

// ### mbt_host_model.sv
// host side model: streams request bytes, collects answer bytes
`timescale 1ns/10ps
module mbt_host_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [8:0] req_q[$];
  logic [8:0] rsp_q[$];
  logic slow = 1'b0;
  always @(posedge mclk) begin
    if (rx_valid && rx_ready) void'(req_q.pop_front());
    if (rst) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_last <= 1'b0;
    end else if (req_q.size() > 0) begin
      rx_valid <= 1'b1;
      rx_data <= req_q[0][7:0];
      rx_last <= req_q[0][8];
    end else begin
      // idle line keeps changing so a stale byte is never mistaken
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      rx_last <= 1'b0;
    end
    tx_ready <= !rst && (slow ? !tx_ready : 1'b1);
    if (tx_valid && tx_ready) rsp_q.push_back({tx_last, tx_data});
  end
endmodule : mbt_host_model

// ### tb.sv
// self-checking bench for the request handler
`timescale 1ns/10ps
module tb;
  logic mclk, rst, conn_up, gw_ok, rx_valid, rx_last, rx_ready;
  logic tx_ready, tx_valid, tx_last, wr_en;
  logic [7:0] local_unit, rx_data, tx_data;
  logic [15:0] wr_addr, wr_data;
  logic [7:0] req[$];
  logic [7:0] none[$];
  logic [31:0] wq[$];
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  mbt_handler u_dut (.mclk(mclk), .rst(rst), .conn_up(conn_up),
    .local_unit(local_unit), .gw_ok(gw_ok), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  mbt_host_model u_host (.mclk(mclk), .rst(rst), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wr_en === 1'b1) wq.push_back({wr_addr, wr_data});
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic w16(input logic [15:0] v);
    req.push_back(v[15:8]);
    req.push_back(v[7:0]);
  endtask : w16
  task automatic hdr(input logic [15:0] tid, len, input logic [7:0] u, fc);
    w16(tid);
    w16(16'h0000);
    w16(len);
    req.push_back(u);
    req.push_back(fc);
  endtask : hdr
  task automatic wreq(input logic [15:0] tid, input logic [7:0] u,
    input logic [15:0] start, n, input logic [7:0] bc);
    hdr(tid, {8'h00, bc} + 16'h0007, u, 8'h10);
    w16(start);
    w16(n);
    req.push_back(bc);
    for (int k = 0; k < bc / 2; k++) w16(k[0] ? 16'h3F80 : 16'h0000);
  endtask : wreq
  task automatic push();
    foreach (req[i]) u_host.req_q.push_back({i == req.size() - 1, req[i]});
    req = {};
  endtask : push
  task automatic run(input logic [7:0] exp[$]);
    push();
    while (u_host.req_q.size() > 0) @(posedge mclk);
    repeat (4) @(posedge mclk);
    while (rx_ready !== 1'b1) @(posedge mclk);
    // one more edge so the write log has taken the last pulse
    @(posedge mclk);
    chk(16'(u_host.rsp_q.size()), 16'(exp.size()));
    foreach (exp[i]) begin
      chk({7'h00, u_host.rsp_q[i]}, {7'h00, (i == exp.size() - 1), exp[i]});
    end
    u_host.rsp_q = {};
  endtask : run
  task automatic wchk(input logic [15:0] start, input int n);
    chk(16'(wq.size()), 16'(n));
    foreach (wq[k]) begin
      chk(wq[k][31:16], start + 16'(k));
      chk(wq[k][15:0], k[0] ? 16'h3F80 : 16'h0000);
    end
    wq = {};
  endtask : wchk
  task automatic t_loop();
    hdr(16'h0001, 16'h0006, 8'h01, 8'h08);
    w16(16'h0000);
    w16(16'h1234);
    run(req);
    hdr(16'h0003, 16'h0006, 8'h05, 8'h08);
    w16(16'h0000);
    w16(16'hBEEF);
    run(req);
    $display("end loopback");
  endtask : t_loop
  task automatic t_write();
    logic [7:0] exp[$];
    hdr(16'hA5C3, 16'h0006, 8'h01, 8'h10);
    w16(16'h00C8);
    w16(16'h0004);
    exp = req;
    req = {};
    wreq(16'hA5C3, 8'h01, 16'h00C8, 16'h0004, 8'h08);
    u_host.slow = 1'b1;
    run(exp);
    u_host.slow = 1'b0;
    wchk(16'h00C8, 4);
    $display("end write");
  endtask : t_write
  task automatic t_bcast();
    wreq(16'h0002, 8'h00, 16'h018E, 16'h0002, 8'h04);
    run(none);
    wchk(16'h018E, 2);
    $display("end broadcast");
  endtask : t_bcast
  task automatic t_exc();
    logic [7:0] exp[$];
    logic [7:0] fc[5] = '{8'h83, 8'h88, 8'h90, 8'h90, 8'h90};
    logic [7:0] ec[5] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h02};
    for (int c = 0; c < 5; c++) begin
      hdr(16'h0100, 16'h0003, 8'h01, fc[c]);
      req.push_back(ec[c]);
      exp = req;
      req = {};
      case (c)
        0: hdr(16'h0100, 16'h0006, 8'h01, 8'h03);
        1: hdr(16'h0100, 16'h0006, 8'h01, 8'h08);
        2: wreq(16'h0100, 8'h01, 16'h0000, 16'h0021, 8'h42);
        3: wreq(16'h0100, 8'h01, 16'h0000, 16'h0002, 8'h06);
        default: wreq(16'h0100, 8'h01, 16'h0190, 16'h0001, 8'h02);
      endcase
      if (c < 2) begin
        w16(16'h0001);
        w16(16'h1234);
      end
      run(exp);
      chk(16'(wq.size()), 16'h0000);
    end
    $display("end exceptions");
  endtask : t_exc
  task automatic t_drop();
    logic [7:0] un[3] = '{8'h05, 8'h64, 8'h00};
    for (int u = 0; u < 4; u++) begin
      gw_ok <= (u != 0);
      hdr(16'h0200, 16'h0006, u < 3 ? un[u] : 8'h01, 8'h08);
      if (u == 3) req[3] = 8'h01;
      w16(16'h0000);
      w16(16'h1234);
      run(none);
    end
    conn_up <= 1'b0;
    hdr(16'h0200, 16'h0006, 8'h01, 8'h08);
    w16(16'h0000);
    w16(16'h1234);
    // ready is registered: let it fall first, or the model drops a byte
    // that the block discarded
    repeat (2) @(posedge mclk);
    push();
    repeat (30) @(posedge mclk);
    chk(16'(u_host.req_q.size()), 16'h000C);
    chk(16'(u_host.rsp_q.size()), 16'h0000);
    u_host.req_q = {};
    conn_up <= 1'b1;
    repeat (4) @(posedge mclk);
    $display("end drops");
  endtask : t_drop
  initial begin
    rst = 1'b1;
    conn_up = 1'b1;
    gw_ok = 1'b1;
    local_unit = 8'h01;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_loop();
    t_write();
    t_bcast();
    t_exc();
    t_drop();
    t_loop();
    summarize();
  end
endmodule : tb
